// File: logic/otg_session_pkg.sv
// Functional notes
// - Bit 19 reports B-session valid; reads 1 when OTG features are off.
// - Bit 18 reports A-session valid; reads 1 when OTG features are off.
// - Bit 17 shows debounce used: 0 long physical, 1 short soft.
// - Bit 16 captures connector identity at connect: 0 A-device, 1 B-device.
// - Bit 9 starts negotiation; hardware clears it when result flag clears.
// - Bit 8 set on negotiation success, cleared when request bit is set.
// - Bit 1 starts session request; hardware clears it when the negotiation result flag (event bit 9) clears.
// - Bit 0 set when session request initiation succeeds.
// - Event bit 20 flags charger input change, write 1 clears, option only.
// - Event bit 19 flags debounce done, only with HNP or SRP capability.
// - Event bit 18 flags A-device timeout waiting for B-device connect.
// - Event bit 17 flags a detected host negotiation request.
// - Event bit 9 flags negotiation outcome; software reads success bit.
// - Event bit 8 flags session request outcome; software reads success bit.
// - Event bit 2 flags B-session valid falling, session end.
// - Bit 22 makes every DMA write request notify and wait, else only last.
// - Bit 21 enables DMA write request and done wait, else complete at once.
// - Bit 8 picks periodic TxFIFO empty level: 0 half, 1 empty.
// - Bit 7 picks non-periodic or endpoint TxFIFO empty level, slave mode.
package otg_session_pkg;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_EVENT = 4'h4;
    localparam logic [3:0] OFS_CFG = 4'h8;
    localparam int CTRL_B_VALID = 19;
    localparam int CTRL_A_VALID = 18;
    localparam int CTRL_DEBOUNCE = 17;
    localparam int CTRL_CONN_ID = 16;
    localparam int CTRL_DEV_HNP = 11;
    localparam int CTRL_HOST_HNP = 10;
    localparam int CTRL_NEG_REQ = 9;
    localparam int CTRL_NEG_OK = 8;
    localparam int CTRL_SES_REQ = 1;
    localparam int CTRL_SES_OK = 0;
    localparam int EV_CHARGER = 20;
    localparam int EV_DEBOUNCE = 19;
    localparam int EV_A_TIMEOUT = 18;
    localparam int EV_NEG_DET = 17;
    localparam int EV_NEG_RESULT = 9;
    localparam int EV_SES_RESULT = 8;
    localparam int EV_SES_END = 2;
    localparam int CFG_NOTIFY_ALL = 22;
    localparam int CFG_REMOTE_MEM = 21;
    localparam int CFG_PTX_LVL = 8;
    localparam int CFG_NPTX_LVL = 7;
    localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
    localparam logic [31:0] EVENT_MASK = 32'h001e_0304;
    localparam logic [31:0] CFG_MASK = 32'h0060_0180;
    localparam int CHARGER_INPUTS = 5;
    typedef enum logic [2:0] {
        DMA_IDLE = 3'b001,
        DMA_REQ = 3'b010,
        DMA_WAIT = 3'b100
    } dma_state_t;
endpackage

// File: logic/otg_session_control_regs.sv
// Local design decision: register access over Wishbone.
`timescale 1ns/1ns
module otg_session_control_regs #(
    parameter bit OTG_FEATURES = 1'b1,
    parameter bit CHARGER_SUPPORT = 1'b0,
    parameter int CHARGER_W = otg_session_pkg::CHARGER_INPUTS
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic b_session_valid_i,
    input wire logic a_session_valid_i,
    input wire logic connector_id_i,
    input wire logic connect_event_i,
    input wire logic short_debounce_i,
    input wire logic debounce_done_i,
    input wire logic a_device_timeout_i,
    input wire logic negotiation_detected_i,
    input wire logic negotiation_done_i,
    input wire logic negotiation_ok_i,
    input wire logic session_done_i,
    input wire logic session_ok_i,
    input wire logic [CHARGER_W-1:0] charger_inputs_i,
    input wire logic negotiation_capable_i,
    input wire logic dma_write_start_i,
    input wire logic dma_last_transact_i,
    input wire logic [3:0] dma_channel_i,
    input wire logic sys_dma_done_i,
    output logic negotiation_request_o,
    output logic session_request_o,
    output logic device_negotiation_enabled_o,
    output logic host_set_negotiation_enabled_o,
    output logic periodic_txfifo_empty_level_o,
    output logic nonperiodic_txfifo_empty_level_o,
    output logic dma_req_o,
    output logic dma_done_o,
    output logic dma_last_o,
    output logic [3:0] dma_channel_o,
    output logic transfer_complete_event_o
);
    if (CHARGER_W < 1 || CHARGER_W > 8)
    begin
        $error("CHARGER_W out of range");
    end

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    localparam int NS = 11 + CHARGER_W;
    logic [NS-1:0] sync1_r;
    logic [NS-1:0] sync2_r;
    logic [NS-1:0] raw_in;
    assign raw_in = {charger_inputs_i, negotiation_capable_i, session_ok_i, session_done_i,
        negotiation_ok_i, negotiation_done_i, negotiation_detected_i, a_device_timeout_i,
        debounce_done_i, short_debounce_i, connect_event_i, connector_id_i};
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
        end
        else
        begin
            sync1_r <= raw_in;
            sync2_r <= sync1_r;
        end
    end

    // Session valid levels feed the read path; B-session valid also feeds the end event
    logic [1:0] ses1_r;
    logic [1:0] ses2_r;
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ses1_r <= 2'h0;
            ses2_r <= 2'h0;
        end
        else
        begin
            ses1_r <= {b_session_valid_i, a_session_valid_i};
            ses2_r <= ses1_r;
        end
    end

    wire conn_id = sync2_r[0];
    wire conn_evt = sync2_r[1];
    wire short_dbn = sync2_r[2];
    wire dbn_done = sync2_r[3];
    wire a_tout = sync2_r[4];
    wire neg_det = sync2_r[5];
    wire neg_done = sync2_r[6];
    wire neg_ok = sync2_r[7];
    wire ses_done = sync2_r[8];
    wire ses_ok = sync2_r[9];
    wire hnp_srp_cap = sync2_r[10];
    wire [CHARGER_W-1:0] charger = sync2_r[NS-1:11];

    // ==========================================================
    // Edge detection on synchronised levels
    // ==========================================================
    // Edges wait until the synchronisers have filled after reset
    logic [2:0] warm_r;
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            warm_r <= 3'h0;
        else
            warm_r <= {warm_r[1:0], 1'b1};
    end
    logic [NS-1:0] prev_r;
    logic b_prev_r;
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            prev_r <= '0;
            b_prev_r <= 1'b0;
        end
        else
        begin
            prev_r <= sync2_r;
            b_prev_r <= ses2_r[1];
        end
    end

    wire [NS-1:0] rise = sync2_r & ~prev_r & {NS{warm_r[2]}};
    wire b_fall = b_prev_r & ~ses2_r[1] & warm_r[2];
    wire charger_chg = warm_r[2] & (charger != prev_r[NS-1:11]);

    // ==========================================================
    // Register bus
    // ==========================================================
    logic ack_r;
    // Registered ack: one wait state, read data latched at the take edge
    wire bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
    // Writes land at the edge where the master samples ack
    wire wr = wb_cyc_i & wb_stb_i & ack_r & wb_we_i;
    wire hit_ctrl = (wb_adr_i == otg_session_pkg::OFS_CTRL);
    wire hit_event = (wb_adr_i == otg_session_pkg::OFS_EVENT);
    wire hit_cfg = (wb_adr_i == otg_session_pkg::OFS_CFG);
    wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0] wbits = wb_dat_i & wmask;
    wire wr_ctrl = wr & hit_ctrl;
    wire wr_event = wr & hit_event;
    wire wr_cfg = wr & hit_cfg;

    // ==========================================================
    // Control and status state
    // ==========================================================
    logic [31:0] event_r;
    logic [31:0] event_nxt;
    logic [31:0] cfg_r;
    logic dev_hnp_r;
    logic host_hnp_r;
    logic neg_req_r;
    logic neg_req_nxt;
    logic ses_req_r;
    logic ses_req_nxt;
    logic neg_ok_r;
    logic ses_ok_r;
    logic conn_id_r;
    logic dbn_r;

    wire [31:0] ev_set;
    assign ev_set[otg_session_pkg::EV_CHARGER] = CHARGER_SUPPORT & charger_chg;
    assign ev_set[otg_session_pkg::EV_DEBOUNCE] = hnp_srp_cap & rise[3];
    assign ev_set[otg_session_pkg::EV_A_TIMEOUT] = rise[4];
    assign ev_set[otg_session_pkg::EV_NEG_DET] = rise[5];
    assign ev_set[otg_session_pkg::EV_NEG_RESULT] = rise[6];
    assign ev_set[otg_session_pkg::EV_SES_RESULT] = rise[8];
    assign ev_set[otg_session_pkg::EV_SES_END] = b_fall;
    assign ev_set[31:21] = '0;
    assign ev_set[16:10] = '0;
    assign ev_set[7:3] = '0;
    assign ev_set[1:0] = '0;

    wire [31:0] ev_clr = wr_event ? wbits : 32'h0000_0000;
    // Set wins over a clear landing in the same cycle
    assign event_nxt = ((event_r & ~ev_clr) | ev_set) & otg_session_pkg::EVENT_MASK;

    // Negotiation result flag going 1 to 0 retires the pending requests
    wire neg_flag_clr = event_r[otg_session_pkg::EV_NEG_RESULT]
        & ~event_nxt[otg_session_pkg::EV_NEG_RESULT];

    always_comb
    begin
        neg_req_nxt = neg_req_r;
        ses_req_nxt = ses_req_r;
        if (wr_ctrl && wb_sel_i[1])
            neg_req_nxt = wb_dat_i[otg_session_pkg::CTRL_NEG_REQ];
        if (wr_ctrl && wb_sel_i[0])
            ses_req_nxt = wb_dat_i[otg_session_pkg::CTRL_SES_REQ];
        if (neg_flag_clr)
            neg_req_nxt = 1'b0;
        if (neg_flag_clr)
            ses_req_nxt = 1'b0;
    end

    // A new negotiation request clears the old negotiation success flag
    wire neg_req_set = neg_req_nxt & ~neg_req_r;

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            event_r <= otg_session_pkg::RESET_VALUE;
            cfg_r <= otg_session_pkg::RESET_VALUE;
            dev_hnp_r <= 1'b0;
            host_hnp_r <= 1'b0;
            neg_req_r <= 1'b0;
            ses_req_r <= 1'b0;
            neg_ok_r <= 1'b0;
            ses_ok_r <= 1'b0;
            conn_id_r <= 1'b0;
            dbn_r <= 1'b0;
            ack_r <= 1'b0;
        end
        else
        begin
            ack_r <= bus_req;
            event_r <= event_nxt;
            // Only the four implemented configuration bits are kept
            if (wr_cfg)
                cfg_r <= ((cfg_r & ~wmask) | wbits) & otg_session_pkg::CFG_MASK;
            if (wr_ctrl && wb_sel_i[1])
                dev_hnp_r <= wb_dat_i[otg_session_pkg::CTRL_DEV_HNP];
            if (wr_ctrl && wb_sel_i[1])
                host_hnp_r <= wb_dat_i[otg_session_pkg::CTRL_HOST_HNP];
            neg_req_r <= neg_req_nxt;
            ses_req_r <= ses_req_nxt;
            // success set, cleared by new request
            if (rise[6] && neg_ok)
                neg_ok_r <= 1'b1;
            else if (neg_req_set)
                neg_ok_r <= 1'b0;
            if (rise[8])
                ses_ok_r <= ses_ok;
            if (rise[1])
                conn_id_r <= conn_id;
            if (rise[1])
                dbn_r <= short_dbn;
        end
    end

    // ==========================================================
    // Read mux
    // ==========================================================
    wire [31:0] ctrl_rd;
    // B-session valid, forced when OTG features are off
    assign ctrl_rd[otg_session_pkg::CTRL_B_VALID] = OTG_FEATURES ? ses2_r[1] : 1'b1;
    // A-session valid, forced when OTG features are off
    assign ctrl_rd[otg_session_pkg::CTRL_A_VALID] = OTG_FEATURES ? ses2_r[0] : 1'b1;
    assign ctrl_rd[otg_session_pkg::CTRL_DEBOUNCE] = dbn_r;
    assign ctrl_rd[otg_session_pkg::CTRL_CONN_ID] = conn_id_r;
    assign ctrl_rd[otg_session_pkg::CTRL_DEV_HNP] = dev_hnp_r;
    assign ctrl_rd[otg_session_pkg::CTRL_HOST_HNP] = host_hnp_r;
    assign ctrl_rd[otg_session_pkg::CTRL_NEG_REQ] = neg_req_r;
    assign ctrl_rd[otg_session_pkg::CTRL_NEG_OK] = neg_ok_r;
    assign ctrl_rd[otg_session_pkg::CTRL_SES_REQ] = ses_req_r;
    assign ctrl_rd[otg_session_pkg::CTRL_SES_OK] = ses_ok_r;
    // Reserved fields read zero
    assign ctrl_rd[31:20] = '0;
    assign ctrl_rd[15:12] = '0;
    assign ctrl_rd[7:2] = '0;

    // Unmapped offsets read zero and ignore writes, still acked
    logic [31:0] rd_r;
    wire [31:0] rd_sel = hit_ctrl ? ctrl_rd : hit_event ? event_r : hit_cfg ? cfg_r : 32'h0000_0000;
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rd_r <= 32'h0000_0000;
        else if (bus_req)
            rd_r <= rd_sel;
    end

    assign wb_dat_o = rd_r;
    assign wb_ack_o = ack_r;

    // ==========================================================
    // DMA write completion handshake
    // ==========================================================
    otg_session_pkg::dma_state_t dma_r;
    otg_session_pkg::dma_state_t dma_nxt;
    logic last_r;
    logic [3:0] chan_r;
    logic xfer_r;
    wire remote = cfg_r[otg_session_pkg::CFG_REMOTE_MEM];
    wire notify_all = cfg_r[otg_session_pkg::CFG_NOTIFY_ALL];
    // A start during REQ or WAIT is dropped, not queued
    // notify every write or only the last
    wire want_notify = remote & (notify_all | dma_last_transact_i);

    always_comb
    begin
        dma_nxt = dma_r;
        case (dma_r)
            otg_session_pkg::DMA_IDLE:
                if (dma_write_start_i && want_notify)
                    dma_nxt = otg_session_pkg::DMA_REQ;
            otg_session_pkg::DMA_REQ:
                dma_nxt = otg_session_pkg::DMA_WAIT;
            otg_session_pkg::DMA_WAIT:
                if (sys_dma_done_i)
                    dma_nxt = otg_session_pkg::DMA_IDLE;
            default:
                dma_nxt = otg_session_pkg::DMA_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            dma_r <= otg_session_pkg::DMA_IDLE;
            last_r <= 1'b0;
            chan_r <= 4'h0;
            xfer_r <= 1'b0;
        end
        else
        begin
            dma_r <= dma_nxt;
            if (dma_r == otg_session_pkg::DMA_IDLE && dma_write_start_i)
            begin
                last_r <= dma_last_transact_i;
                chan_r <= dma_channel_i;
            end
            // complete at once without remote wait, else after system done
            xfer_r <= (dma_r == otg_session_pkg::DMA_IDLE && dma_write_start_i
                && dma_last_transact_i && !remote)
                || (dma_r == otg_session_pkg::DMA_WAIT && sys_dma_done_i && last_r);
        end
    end

    assign dma_req_o = (dma_r != otg_session_pkg::DMA_IDLE);
    assign dma_done_o = (dma_r == otg_session_pkg::DMA_WAIT);
    assign dma_last_o = last_r;
    assign dma_channel_o = chan_r;
    assign transfer_complete_event_o = xfer_r;

    assign negotiation_request_o = neg_req_r;
    assign session_request_o = ses_req_r;
    assign device_negotiation_enabled_o = dev_hnp_r;
    assign host_set_negotiation_enabled_o = host_hnp_r;

    assign periodic_txfifo_empty_level_o = cfg_r[otg_session_pkg::CFG_PTX_LVL];
    assign nonperiodic_txfifo_empty_level_o = cfg_r[otg_session_pkg::CFG_NPTX_LVL];
endmodule

// File: testbench/otg_session_control_regs_monitor.sv
`timescale 1ns/1ns
module otg_session_control_regs_monitor (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic sys_dma_done_i,
    input wire logic negotiation_request_o,
    input wire logic session_request_o,
    input wire logic periodic_txfifo_empty_level_o,
    input wire logic nonperiodic_txfifo_empty_level_o,
    input wire logic dma_req_o,
    input wire logic dma_done_o,
    input wire logic transfer_complete_event_o
);
    // ==========================================
    // Bus decode seen from outside
    wire take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr_ack = wb_ack_o & wb_we_i & (wb_sel_i[1:0] == 2'b11);
    wire neg_bit = wb_dat_i[9];
    wire ses_bit = wb_dat_i[1];
    wire p_bit = wb_dat_i[8];
    wire np_bit = wb_dat_i[7];
    wire mapped = (wb_adr_i == 4'h0) | (wb_adr_i == 4'h4) | (wb_adr_i == 4'h8);
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);
    // ==========================================
    // Properties
    ack_after_take_a: assert property (take |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    neg_req_write_a: assert property (
        wr_ack && wb_adr_i == 4'h0 |=> negotiation_request_o == $past(neg_bit))
        else $error("negotiation request does not follow write");
    ses_req_write_a: assert property (
        wr_ack && wb_adr_i == 4'h0 |=> session_request_o == $past(ses_bit))
        else $error("session request does not follow write");
    fifo_level_write_a: assert property (wr_ack && wb_adr_i == 4'h8 |=>
        periodic_txfifo_empty_level_o == $past(p_bit)
        && nonperiodic_txfifo_empty_level_o == $past(np_bit))
        else $error("fifo level outputs do not follow write");
    unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && !mapped |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    dma_done_req_a: assert property (dma_done_o |-> dma_req_o)
        else $error("dma done without dma request");
    dma_wait_hold_a: assert property (
        dma_done_o && !sys_dma_done_i |=> dma_done_o)
        else $error("dma done dropped before system done");
    complete_pulse_a: assert property (
        transfer_complete_event_o |=> !transfer_complete_event_o)
        else $error("transfer complete longer than one cycle");
endmodule

// File: testbench/otg_peer_model.sv
`timescale 1ns/1ns
module otg_peer_model (
    input wire logic clk_sys_i,
    input wire logic negotiation_request_i,
    input wire logic session_request_i,
    input wire logic grant_i,
    output logic negotiation_done_o,
    output logic negotiation_ok_o,
    output logic session_done_o,
    output logic session_ok_o
);
    int neg_cnt = 0;
    int ses_cnt = 0;
    initial
    begin
        negotiation_done_o = 1'b0;
        negotiation_ok_o = 1'b0;
        session_done_o = 1'b0;
        session_ok_o = 1'b0;
    end
    // ==========================================
    // Slow replies, ok settles before done rises
    // Outside a reply ok shows the inverse so a stale level cannot pass
    // negotiation reply
    always @(posedge clk_sys_i)
    begin
        neg_cnt <= negotiation_request_i ? neg_cnt + 1 : 0;
        negotiation_done_o <= negotiation_request_i && neg_cnt >= 10;
        negotiation_ok_o <= (negotiation_request_i && neg_cnt >= 9) ? grant_i : !grant_i;
    end
    always @(posedge clk_sys_i)
    begin
        ses_cnt <= session_request_i ? ses_cnt + 1 : 0;
        session_done_o <= session_request_i && ses_cnt >= 10;
        session_ok_o <= (session_request_i && ses_cnt >= 9) ? grant_i : !grant_i;
    end
endmodule

// File: testbench/otg_session_control_regs_tb.sv
`timescale 1ns/1ns
module otg_session_control_regs_tb;
    logic clk_sys_i = 1'b0, rst_n_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf, dma_channel_i = 4'h0, dma_channel_o;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic b_session_valid_i = 1'b1, a_session_valid_i = 1'b1, connector_id_i = 1'b0;
    logic connect_event_i = 1'b0, short_debounce_i = 1'b0, debounce_done_i = 1'b0;
    logic a_device_timeout_i = 1'b0, negotiation_detected_i = 1'b0, negotiation_capable_i = 1'b1;
    logic dma_write_start_i = 1'b0, dma_last_transact_i = 1'b0, sys_dma_done_i = 1'b0;
    logic [otg_session_pkg::CHARGER_INPUTS-1:0] charger_inputs_i = '0;
    logic grant = 1'b0, wb_ack_o, negotiation_done_i, negotiation_ok_i, session_done_i;
    logic session_ok_i, negotiation_request_o, session_request_o, device_negotiation_enabled_o;
    logic host_set_negotiation_enabled_o, periodic_txfifo_empty_level_o, dma_req_o, dma_done_o;
    logic nonperiodic_txfifo_empty_level_o, dma_last_o, transfer_complete_event_o;
    int err_count = 0;
    int checks = 0;
    otg_session_control_regs u_dut (.clk_sys_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .b_session_valid_i,
        .a_session_valid_i, .connector_id_i, .connect_event_i, .short_debounce_i,
        .debounce_done_i, .a_device_timeout_i, .negotiation_detected_i, .negotiation_done_i,
        .negotiation_ok_i, .session_done_i, .session_ok_i, .charger_inputs_i,
        .negotiation_capable_i, .dma_write_start_i, .dma_last_transact_i, .dma_channel_i,
        .sys_dma_done_i, .negotiation_request_o, .session_request_o,
        .device_negotiation_enabled_o, .host_set_negotiation_enabled_o,
        .periodic_txfifo_empty_level_o, .nonperiodic_txfifo_empty_level_o, .dma_req_o,
        .dma_done_o, .dma_last_o, .dma_channel_o, .transfer_complete_event_o);
    otg_peer_model u_peer (.clk_sys_i, .grant_i(grant),
        .negotiation_request_i(negotiation_request_o), .session_request_i(session_request_o),
        .negotiation_done_o(negotiation_done_i), .negotiation_ok_o(negotiation_ok_i),
        .session_done_o(session_done_i), .session_ok_o(session_ok_i));
    initial
    begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    // ==========================================
    // Shared tasks
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic bail(input string what);
        err_count++;
        $display("MISMATCH %s expected answer seen timeout", what);
        tally_and_finish();
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    // Ack and read data are taken at the edge that samples ack high
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do
        begin
            @(posedge clk_sys_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20)
            bail("wb_ack_o");
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rdchk(input string name, input logic [3:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(name, exp, rd);
    endtask
    task automatic poll(input int b);
        int n;
        n = 0;
        do
        begin
            wb(1'b0, 4'h4, 32'h0);
            n++;
        end
        while (rd[b] !== 1'b1 && n < 30);
        if (n >= 30)
            bail("event poll");
    endtask
    // ==========================================
    // Scenarios
    task automatic t_reset();
        // Let the input synchronisers fill before the first read
        idle(3);
        rdchk("ctrl", 4'h0, 32'h000c_0000);
        rdchk("event", 4'h4, 32'h0);
        rdchk("cfg", 4'h8, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_events();
        connector_id_i <= 1'b1;
        short_debounce_i <= 1'b1;
        idle(5);
        connect_event_i <= 1'b1;
        debounce_done_i <= 1'b1;
        a_device_timeout_i <= 1'b1;
        negotiation_detected_i <= 1'b1;
        b_session_valid_i <= 1'b0;
        charger_inputs_i <= 5'h15;
        idle(5);
        rdchk("ctrl", 4'h0, 32'h0007_0000);
        rdchk("event", 4'h4, 32'h000e_0004);
        wb(1'b1, 4'h4, 32'hffff_ffff);
        rdchk("event", 4'h4, 32'h0);
        negotiation_capable_i <= 1'b0;
        debounce_done_i <= 1'b0;
        idle(5);
        debounce_done_i <= 1'b1;
        idle(5);
        rdchk("event", 4'h4, 32'h0);
        negotiation_capable_i <= 1'b1;
        $display("test events done");
    endtask
    task automatic t_hnp();
        grant <= 1'b1;
        wb(1'b1, 4'h0, 32'h0000_0e00);
        poll(9);
        rdchk("ctrl", 4'h0, 32'h0007_0f00);
        chk("hnp enables", 32'h3, {30'h0, device_negotiation_enabled_o,
            host_set_negotiation_enabled_o});
        wb(1'b1, 4'h4, 32'h0000_0200);
        rdchk("ctrl", 4'h0, 32'h0007_0d00);
        grant <= 1'b0;
        wb(1'b1, 4'h0, 32'h0000_0e00);
        rdchk("ctrl", 4'h0, 32'h0007_0e00);
        poll(9);
        rdchk("ctrl", 4'h0, 32'h0007_0e00);
        wb(1'b1, 4'h4, 32'h0000_0200);
        rdchk("ctrl", 4'h0, 32'h0007_0c00);
        $display("test negotiation done");
    endtask
    task automatic t_srp();
        // B-session valid is already low; let VBUS discharge
        idle(5);
        for (int g = 0; g < 2; g++)
        begin
            grant <= g[0];
            wb(1'b1, 4'h0, 32'h0000_0c02);
            idle(1);
            chk("ses req", 32'h1, {31'h0, session_request_o});
            poll(8);
            rdchk("ctrl", 4'h0, {31'h0003_8601, g[0]});
            wb(1'b1, 4'h4, 32'h0000_0100);
            wb(1'b1, 4'h0, 32'h0000_0c00);
            rdchk("event", 4'h4, 32'h0);
        end
        $display("test session done");
    endtask
    task automatic t_cfg();
        wb(1'b1, 4'h8, 32'hffff_ffff);
        rdchk("cfg", 4'h8, otg_session_pkg::CFG_MASK);
        chk("levels", 32'h3, {30'h0, periodic_txfifo_empty_level_o,
            nonperiodic_txfifo_empty_level_o});
        wb(1'b1, 4'h8, 32'h0000_0080);
        wb(1'b1, 4'hc, 32'hffff_ffff);
        rdchk("unmapped", 4'hc, 32'h0);
        chk("levels", 32'h1, {30'h0, periodic_txfifo_empty_level_o,
            nonperiodic_txfifo_empty_level_o});
        $display("test config done");
    endtask
    task automatic t_dma();
        int reqs;
        int tcs;
        int nd;
        logic [3:0] ch;
        logic [2:0] tbl [5] = '{3'b010, 3'b011, 3'b110, 3'b001, 3'b100};
        for (int i = 0; i < 5; i++)
        begin
            wb(1'b1, 4'h8, {9'h0, tbl[i][2:1], 21'h0});
            @(posedge clk_sys_i);
            dma_write_start_i <= 1'b1;
            dma_last_transact_i <= tbl[i][0];
            dma_channel_i <= i[3:0] + 4'h3;
            @(posedge clk_sys_i);
            dma_write_start_i <= 1'b0;
            reqs = 0;
            tcs = 0;
            nd = 0;
            ch = 4'h0;
            repeat (20)
            begin
                @(posedge clk_sys_i);
                reqs += int'(dma_req_o === 1'b1);
                tcs += int'(transfer_complete_event_o === 1'b1);
                if (dma_req_o === 1'b1)
                    ch = dma_channel_o;
                nd = (dma_done_o === 1'b1) ? nd + 1 : 0;
                sys_dma_done_i <= (nd >= 3);
            end
            chk("dma req", {31'h0, tbl[i][1] & (tbl[i][2] | tbl[i][0])},
                {31'h0, reqs > 0});
            chk("complete", {31'h0, tbl[i][0]}, tcs);
            if (reqs > 0)
                chk("channel", {28'h0, i[3:0] + 4'h3}, {28'h0, ch});
            chk("last", {31'h0, tbl[i][0]}, {31'h0, dma_last_o});
        end
        $display("test dma done");
    endtask
    initial
    begin
        idle(8);
        rst_n_i <= 1'b1;
        t_reset();
        t_events();
        t_hnp();
        t_srp();
        t_cfg();
        t_dma();
        tally_and_finish();
    end
endmodule
bind otg_session_control_regs otg_session_control_regs_monitor u_mon (.clk_sys_i, .rst_n_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .sys_dma_done_i, .negotiation_request_o, .session_request_o,
    .periodic_txfifo_empty_level_o, .nonperiodic_txfifo_empty_level_o, .dma_req_o,
    .dma_done_o, .transfer_complete_event_o);
